// >>> ssdp_top.sv
// spi master status and data port: apb registers, fifos, shift engine
// assumes shift_clk and spi_miso arrive from outside the pclk domain
//
// The APB interface to the registers was decided locally.
`default_nettype none

module ssdp_top
  import ssdp_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // interrupt
  output logic                   irq,
  // spi link
  input  wire logic              shift_clk,
  input  wire logic              spi_miso,
  output logic                   spi_sclk,
  output logic                   spi_mosi,
  output logic                   spi_cs_n
);

  // apb
  logic            ack_reg;
  logic [31:0]     rdata_reg;
  logic            err_reg;
  logic            access;
  logic            wr_take;
  logic            rd_load;
  logic            addr_ok;
  // registers
  ssdp_ctrl_type   ctrl_reg;
  logic [DELAY_W-1:0] interframe_delay_reg;
  logic [EVENT_W-1:0] mask_reg;
  logic [EVENT_W-1:0] event_reg;
  logic            tx_overrun_reg;
  ssdp_status_type spi_status;
  // fifos
  logic            tx_push;
  logic            tx_pop;
  logic [DATA_W-1:0] tx_dout;
  logic [CNT_W-1:0] tx_fifo_count;
  logic            tx_full;
  logic            tx_empty;
  logic            rx_push;
  logic            rx_pop;
  logic [DATA_W-1:0] rx_din;
  logic [DATA_W-1:0] rx_dout;
  logic [CNT_W-1:0] rx_fifo_count;
  logic            rx_empty;
  // link
  logic            sck_meta_reg;
  logic            sck_sync_reg;
  logic            sck_last_reg;
  logic            miso_meta_reg;
  logic            miso_sync_reg;
  logic            tick;
  ssdp_state_type  state_reg;
  logic [DATA_W-1:0] tx_shift_reg;
  logic [DATA_W-1:0] rx_shift_reg;
  logic [DATA_W-1:0] rx_shift_next;
  logic [4:0]      bit_cnt_reg;
  logic [DELAY_W-1:0] gap_cnt_reg;
  logic            sclk_reg;
  logic            mosi_reg;
  logic            cs_n_reg;
  logic            byte_mode;
  logic [4:0]      frame_bits;
  logic            can_start;
  logic            frame_done;
  logic [EVENT_W-1:0] events;

  assign access  = psel && penable;
  assign rd_load = access && !ack_reg && !pwrite;
  assign wr_take = access && ack_reg && pwrite;
  assign pready  = ack_reg;
  assign pslverr = ack_reg && err_reg;
  assign prdata  = rdata_reg;

  assign addr_ok = (paddr == STATUS_ADDR) || (paddr == DATA_ADDR) ||
                   (paddr == CTRL_ADDR) || (paddr == DELAY_ADDR) ||
                   (paddr == MASK_ADDR) || (paddr == EVENT_ADDR);

  // one wait state so read data always comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= access && !ack_reg;
      err_reg <= access && !ack_reg && !addr_ok;
    end
  end

  // status word assembly
  always_comb
  begin
    spi_status = '0;
    spi_status.tx_level_irq_flag =
      ((FIFO_DEPTH - tx_fifo_count) >= TX_FREE_LEVEL);
    spi_status.rx_level_irq_flag =
      (rx_fifo_count >= RX_FILL_LEVEL);
    spi_status.tx_fifo_count = tx_fifo_count;
    spi_status.rx_fifo_count = rx_fifo_count;
    spi_status.tx_overrun_flag = tx_overrun_reg;
    spi_status.gap_delay_flag = (state_reg == SH_GAP);
    spi_status.idle_flag = (state_reg != SH_SHIFT) &&
      (tx_empty || ctrl_reg.stop_request);
    spi_status.tx_space_flag = !tx_full;
    spi_status.rx_available_flag = !rx_empty;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_reg <= 32'h0;
    end
    else if (rd_load)
    begin
      case (paddr)
        STATUS_ADDR: rdata_reg <= spi_status;
        DATA_ADDR:   rdata_reg <= rx_empty ? 32'h0 : {16'h0, rx_dout};
        CTRL_ADDR:   rdata_reg <= {19'h0, ctrl_reg.frame_size_select,
                                   6'h0, ctrl_reg.stop_request,
                                   ctrl_reg.config_mode};
        DELAY_ADDR:  rdata_reg <= {22'h0, interframe_delay_reg};
        MASK_ADDR:   rdata_reg <= {29'h0, mask_reg};
        EVENT_ADDR:  rdata_reg <= {29'h0, event_reg};
        default:     rdata_reg <= 32'h0;
      endcase
    end
  end

  // control and configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg.config_mode       <= CFG_RESET;
      ctrl_reg.stop_request      <= 1'b0;
      ctrl_reg.frame_size_select <= SIZE_RESET;
      interframe_delay_reg       <= 10'h0;
      mask_reg                   <= 3'h0;
    end
    else if (wr_take)
    begin
      if (paddr == CTRL_ADDR)
      begin
        ctrl_reg.config_mode  <= pwdata[CTRL_CFG_BIT];
        ctrl_reg.stop_request <= pwdata[CTRL_STOP_BIT];
        // size may change only in configuration mode
        if (ctrl_reg.config_mode)
        begin
          ctrl_reg.frame_size_select <=
            pwdata[CTRL_SIZE_LSB +: SIZE_W];
        end
      end
      if (paddr == DELAY_ADDR)
      begin
        interframe_delay_reg <= pwdata[DELAY_W-1:0];
      end
      if (paddr == MASK_ADDR)
      begin
        mask_reg <= pwdata[EVENT_W-1:0];
      end
    end
  end

  // reserved size codes fall back to sixteen bit frames
  assign byte_mode  = (ctrl_reg.frame_size_select == SIZE_8);
  assign frame_bits = byte_mode ? BITS_8 : BITS_16;
  assign tx_push = wr_take && (paddr == DATA_ADDR);
  assign rx_pop  = rd_load && (paddr == DATA_ADDR);

  // overrun: hardware set wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_overrun_reg <= 1'b0;
    end
    else if (tx_push && tx_full)
    begin
      tx_overrun_reg <= 1'b1;
    end
    else if (ctrl_reg.config_mode ||
             (wr_take && (paddr == STATUS_ADDR) && pwdata[STATUS_OVR_BIT]))
    begin
      tx_overrun_reg <= 1'b0;
    end
  end

  ssdp_fifo u_tx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (tx_push),
    .din     (byte_mode ? {8'h00, pwdata[7:0]} : pwdata[DATA_W-1:0]),
    .pop     (tx_pop),
    .dout    (tx_dout),
    .count   (tx_fifo_count),
    .full    (tx_full),
    .empty   (tx_empty)
  );

  ssdp_fifo u_rx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (rx_push),
    .din     (rx_din),
    .pop     (rx_pop),
    .dout    (rx_dout),
    .count   (rx_fifo_count),
    .full    (),
    .empty   (rx_empty)
  );

  // link inputs pass two flops; edge found on the synced copy only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_meta_reg  <= 1'b0;
      sck_sync_reg  <= 1'b0;
      sck_last_reg  <= 1'b0;
      miso_meta_reg <= 1'b0;
      miso_sync_reg <= 1'b0;
    end
    else
    begin
      sck_meta_reg  <= shift_clk;
      sck_sync_reg  <= sck_meta_reg;
      sck_last_reg  <= sck_sync_reg;
      miso_meta_reg <= spi_miso;
      miso_sync_reg <= miso_meta_reg;
    end
  end

  assign tick = sck_sync_reg && !sck_last_reg;
  assign can_start  = !tx_empty && !ctrl_reg.stop_request &&
                      !ctrl_reg.config_mode;
  assign tx_pop     = (state_reg == SH_IDLE) && can_start;
  assign frame_done = (state_reg == SH_SHIFT) && tick && sclk_reg &&
                      (bit_cnt_reg == frame_bits - 5'h1);
  assign rx_push    = frame_done;
  // miso taken just before sclk falls; sync lag spoils an early first rise
  assign rx_shift_next = {rx_shift_reg[14:0], miso_sync_reg};
  // upper byte forced to zero for eight bit frames
  assign rx_din     = byte_mode ? {8'h00, rx_shift_next[7:0]}
                                : rx_shift_next;

  // shift engine: mode 0, msb first; each shift clock rising edge is a half bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg    <= SH_IDLE;
      tx_shift_reg <= 16'h0;
      rx_shift_reg <= 16'h0;
      bit_cnt_reg  <= 5'h0;
      gap_cnt_reg  <= 10'h0;
      sclk_reg     <= 1'b0;
      mosi_reg     <= 1'b0;
      cs_n_reg     <= 1'b1;
    end
    else
    begin
      case (state_reg)
        SH_IDLE:
        begin
          if (can_start)
          begin
            state_reg    <= SH_SHIFT;
            tx_shift_reg <= byte_mode ? {tx_dout[7:0], 8'h00} : tx_dout;
            mosi_reg     <= byte_mode ? tx_dout[7] : tx_dout[15];
            bit_cnt_reg  <= 5'h0;
            cs_n_reg     <= 1'b0;
          end
        end
        SH_SHIFT:
        begin
          if (tick && !sclk_reg)
          begin
            sclk_reg     <= 1'b1;
          end
          else if (tick)
          begin
            sclk_reg     <= 1'b0;
            rx_shift_reg <= rx_shift_next;
            if (frame_done)
            begin
              cs_n_reg <= 1'b1;
              if (can_start && (interframe_delay_reg != 10'h0))
              begin
                state_reg   <= SH_GAP;
                gap_cnt_reg <= interframe_delay_reg;
              end
              else
              begin
                state_reg <= SH_IDLE;
              end
            end
            else
            begin
              bit_cnt_reg  <= bit_cnt_reg + 5'h1;
              tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
              mosi_reg     <= tx_shift_reg[14];
            end
          end
        end
        SH_GAP:
        begin
          if (tick)
          begin
            gap_cnt_reg <= gap_cnt_reg - 10'h1;
            if (gap_cnt_reg == 10'h1)
            begin
              state_reg <= SH_IDLE;
            end
          end
        end
        default:
        begin
          state_reg <= SH_IDLE;
          cs_n_reg  <= 1'b1;
          sclk_reg  <= 1'b0;
        end
      endcase
    end
  end

  assign spi_sclk = sclk_reg;
  assign spi_mosi = mosi_reg;
  assign spi_cs_n = cs_n_reg;

  // sticky events; a read clears, a new event in that cycle still lands
  assign events = {rx_push, tx_push && tx_full, frame_done};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      event_reg <= 3'h0;
      irq       <= 1'b0;
    end
    else
    begin
      event_reg <= events |
        ((rd_load && (paddr == EVENT_ADDR)) ? 3'h0 : event_reg);
      irq       <= |((event_reg | events) & mask_reg);
    end
  end

endmodule

`default_nettype wire

// >>> ssdp_pkg.sv
// constants, field layouts and carrier types of the spi status and data port
// assumes an apb master on pclk and a free running shift clock input pin
`default_nettype none

package ssdp_pkg;

  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned CNT_W        = 3;
  localparam int unsigned DELAY_W      = 10;
  localparam int unsigned SIZE_W       = 5;
  localparam int unsigned EVENT_W      = 3;

  // register byte addresses
  localparam logic [15:0] STATUS_ADDR  = 16'hf814;
  localparam logic [15:0] DATA_ADDR    = 16'hf818;
  localparam logic [15:0] CTRL_ADDR    = 16'hf81c;
  localparam logic [15:0] DELAY_ADDR   = 16'hf820;
  localparam logic [15:0] MASK_ADDR    = 16'hf824;
  localparam logic [15:0] EVENT_ADDR   = 16'hf828;

  // control register layout and the overrun clear bit of status
  localparam int unsigned CTRL_CFG_BIT   = 0;
  localparam int unsigned CTRL_STOP_BIT  = 1;
  localparam int unsigned CTRL_SIZE_LSB  = 8;
  localparam int unsigned STATUS_OVR_BIT = 7;

  localparam logic [4:0] SIZE_8        = 5'h08;
  localparam logic [4:0] SIZE_16       = 5'h10;
  localparam logic [4:0] SIZE_RESET    = 5'h08;
  localparam logic       CFG_RESET     = 1'b1;

  // fifo depth and interrupt levels
  localparam logic [2:0] FIFO_DEPTH    = 3'h4;
  localparam logic [2:0] TX_FREE_LEVEL = 3'h2;
  localparam logic [2:0] RX_FILL_LEVEL = 3'h2;

  // bit counts per frame, counted in whole serial clock periods
  localparam logic [4:0] BITS_8        = 5'h08;
  localparam logic [4:0] BITS_16       = 5'h10;

  // event bits of the sticky event register
  localparam int unsigned EV_DONE_BIT  = 0;
  localparam int unsigned EV_OVR_BIT   = 1;
  localparam int unsigned EV_RX_BIT    = 2;

  typedef enum logic [1:0] {
    SH_IDLE  = 2'b00,
    SH_SHIFT = 2'b01,
    SH_GAP   = 2'b11
  } ssdp_state_type;

  typedef struct packed {
    logic [15:0] reserved;
    logic        tx_level_irq_flag;
    logic        rx_level_irq_flag;
    logic [2:0]  tx_fifo_count;
    logic [2:0]  rx_fifo_count;
    logic        tx_overrun_flag;
    logic [2:0]  zero_6_4;
    logic        gap_delay_flag;
    logic        idle_flag;
    logic        tx_space_flag;
    logic        rx_available_flag;
  } ssdp_status_type;

  typedef struct packed {
    logic       config_mode;
    logic       stop_request;
    logic [4:0] frame_size_select;
  } ssdp_ctrl_type;

endpackage

`default_nettype wire

// >>> ssdp_fifo.sv
// four entry first in first out store used for transmit and receive words
// assumes push and pop come from logic on the same clock
`default_nettype none

module ssdp_fifo
  import ssdp_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // fill side
  input  wire logic              push,
  input  wire logic [DATA_W-1:0] din,
  // drain side
  input  wire logic              pop,
  output logic [DATA_W-1:0]      dout,
  // state
  output logic [CNT_W-1:0]       count,
  output logic                   full,
  output logic                   empty
);

  logic [DATA_W-1:0] mem [4];
  logic [1:0]        rd_ptr_reg;
  logic [1:0]        wr_ptr_reg;
  logic [CNT_W-1:0]  count_reg;
  logic              do_push;
  logic              do_pop;

  assign full    = (count_reg == FIFO_DEPTH);
  assign empty   = (count_reg == 3'h0);
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign count   = count_reg;
  assign dout    = mem[rd_ptr_reg];

  always_ff @(posedge pclk)
  begin
    if (do_push)
    begin
      mem[wr_ptr_reg] <= din;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ptr_reg <= 2'h0;
      wr_ptr_reg <= 2'h0;
      count_reg  <= 3'h0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 2'h1;
      end
      if (do_pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      end
      if (do_push && !do_pop)
      begin
        count_reg <= count_reg + 3'h1;
      end
      else if (do_pop && !do_push)
      begin
        count_reg <= count_reg - 3'h1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> ssdp_props.sv
// concurrent checks on the apb and link ports of the status and data port
// assumes it is bound onto ssdp_top and sees every port of it
`default_nettype none

module ssdp_props
  import ssdp_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irq,
  // link
  input wire logic              shift_clk,
  input wire logic              spi_miso,
  input wire logic              spi_sclk,
  input wire logic              spi_mosi,
  input wire logic              spi_cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic st_rd;

  assign st_rd = pready && !pslverr && !pwrite && paddr == STATUS_ADDR;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  access_len_a: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("access phase not two cycles long");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without a pending access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  tx_count_a: assert property (
    st_rd |-> prdata[13:11] <= FIFO_DEPTH)
    else $error("transmit count above four");
  rx_count_a: assert property (
    st_rd |-> prdata[10:8] <= FIFO_DEPTH)
    else $error("receive count above four");
  tx_space_a: assert property (
    st_rd |-> prdata[1] == (prdata[13:11] != FIFO_DEPTH))
    else $error("transmit space flag disagrees with count");
  rx_avail_a: assert property (
    st_rd |-> prdata[0] == (prdata[10:8] != 3'h0))
    else $error("receive flag disagrees with count");
  tx_level_a: assert property (
    st_rd |-> prdata[15] == (FIFO_DEPTH - prdata[13:11] >= TX_FREE_LEVEL))
    else $error("transmit level flag wrong");
  rx_level_a: assert property (
    st_rd |-> prdata[14] == (prdata[10:8] >= RX_FILL_LEVEL))
    else $error("receive level flag wrong");
  sclk_idle_a: assert property (spi_cs_n |-> !spi_sclk)
    else $error("serial clock high outside a frame");
endmodule

bind ssdp_top ssdp_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .shift_clk(shift_clk),
  .spi_miso(spi_miso), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
  .spi_cs_n(spi_cs_n)
);

`default_nettype wire

// >>> ssdp_slave_model.sv
// behavioural spi slave, mode 0, msb first, width set by the bench
// assumes cs_n frames every transfer; replies with the last word inverted
`default_nettype none

module ssdp_slave_model
(
  // from the master
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  input  wire logic [4:0] bits,
  // reply
  output logic            spi_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] in_sr, out_sr, last_word;
  logic        in_frame;
  logic [15:0] got_q[$];

  initial
  begin
    in_sr = 16'h0;
    out_sr = 16'h0;
    last_word = 16'h5a5a;
    in_frame = 1'b0;
    spi_miso = 1'b0;
  end

  always @(negedge spi_cs_n)
  begin
    in_frame = 1'b1;
    out_sr = (~last_word) << (5'h10 - bits);
    spi_miso = out_sr[15];
  end

  always @(posedge spi_sclk)
    in_sr = {in_sr[14:0], spi_mosi};

  always @(negedge spi_sclk)
  begin
    out_sr = out_sr << 1;
    spi_miso = out_sr[15];
  end

  // the x to one edge at reset is no frame, hence the guard
  always @(posedge spi_cs_n)
  begin
    if (in_frame)
    begin
      last_word = (bits == 5'h10) ? in_sr : {8'h0, in_sr[7:0]};
      got_q.push_back(last_word);
    end
    in_frame = 1'b0;
    spi_miso = ~spi_miso;
  end
endmodule

`default_nettype wire

// >>> spi_status_and_data_port_tb.sv
// self-checking bench: apb master, free shift clock, slave model on link
// assumes the two cycle access phase and register map of ssdp_top
`default_nettype none

module spi_status_and_data_port_tb import ssdp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              pclk, presetn, psel, penable, pwrite, e, g;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, r;
  logic              pready, pslverr, irq, shift_clk;
  logic              spi_miso, spi_sclk, spi_mosi, spi_cs_n;
  logic [4:0]        bits;
  logic [15:0]       prev, mask;
  logic [15:0]       w [4];
  logic [15:0]       exp_q[$];
  int                n_errors, comparisons;

  ssdp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .shift_clk(shift_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n));
  ssdp_slave_model u_slave (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .bits(bits), .spi_miso(spi_miso));

  always #12.5 pclk = ~pclk;

  initial
  begin
    shift_clk = 1'b0;
    #7;
    forever #100 shift_clk = ~shift_clk;
  end

  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] exp_st(int tx, int rx, logic ov, logic id);
    return {16'h0, 1'(4 - tx >= 2), 1'(rx >= 2), 3'(tx), 3'(rx), ov,
            4'h0, id, 1'(tx != 4), 1'(rx != 0)};
  endfunction

  // holds the request until pready is sampled, then one idle cycle
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t == 20)
      n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic send(input int n);
    for (int j = 0; j < n; j++)
    begin
      w[j] = 16'($urandom) & mask;
      apb(1'b1, DATA_ADDR, {16'h0, w[j]});
      exp_q.push_back(~prev & mask);
      prev = w[j];
    end
  endtask

  task automatic wait_idle(input int n);
    int t;
    g = 1'b0;
    t = 0;
    do
    begin
      apb(1'b0, STATUS_ADDR, 32'h0);
      g = g | r[3];
      t++;
    end while (!(r[2] && r[10:8] == 3'(n) && r[13:11] == 3'h0) && t < 900);
    if (t == 900)
      n_errors++;
  endtask

  task automatic drain(input int n);
    for (int j = 0; j < n; j++)
    begin
      apb(1'b0, DATA_ADDR, 32'h0);
      chk(r, {16'h0, exp_q.pop_front()});
      chk({16'h0, u_slave.got_q.pop_front()}, {16'h0, w[j]});
    end
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pclk = 1'b0;
    bits = 5'h08;
    mask = 16'h00ff;
    prev = 16'h5a5a;
    n_errors = 0;
    comparisons = 0;
    void'($urandom(32'ha08b2599));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(r, exp_st(0, 0, 1'b0, 1'b1));
    apb(1'b0, 16'hf830, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h0802);
    send(4);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(r, exp_st(4, 0, 1'b0, 1'b1));
    apb(1'b1, DATA_ADDR, 32'h1234);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(r, exp_st(4, 0, 1'b1, 1'b1));
    apb(1'b1, STATUS_ADDR, 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk({31'h0, r[7]}, 32'h1);
    apb(1'b1, STATUS_ADDR, 32'h80);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(r, exp_st(4, 0, 1'b0, 1'b1));
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, EVENT_ADDR, 32'h0);
    chk(r, 32'h2);
    apb(1'b1, MASK_ADDR, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h0800);
    wait_idle(4);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, EVENT_ADDR, 32'h0);
    chk(r, 32'h5);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(r, exp_st(0, 4, 1'b0, 1'b1));
    drain(4);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(r, exp_st(0, 0, 1'b0, 1'b1));
    apb(1'b1, CTRL_ADDR, 32'h0801);
    apb(1'b1, CTRL_ADDR, 32'h1001);
    apb(1'b1, CTRL_ADDR, 32'h1000);
    apb(1'b1, MASK_ADDR, 32'h0);
    bits = 5'h10;
    mask = 16'hffff;
    send(3);
    apb(1'b1, DELAY_ADDR, 32'h3);
    wait_idle(3);
    chk({31'h0, g}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    drain(3);
    apb(1'b1, CTRL_ADDR, 32'h1002);
    repeat (5) apb(1'b1, DATA_ADDR, 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk({31'h0, r[7]}, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h1003);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk({31'h0, r[7]}, 32'h0);
    end_sim;
  end

  initial
  begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    end_sim;
  end
endmodule

`default_nettype wire
